// File: inc/nbi_pkg.sv
// package: constants, types and address packing for the nand bus host
package nbi_pkg;

  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned CLK_NS         = 20;
  // strobe phase times in ns, and cycles derived from them (least times round up)
  localparam int unsigned T_SETUP_NS     = 20;
  localparam int unsigned T_PULSE_NS     = 20;
  localparam int unsigned T_HOLD_NS      = 20;
  localparam int unsigned T_EDO_RC_NS    = 30;
  localparam logic [3:0]  SETUP_CYC      = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  PULSE_CYC      = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  HOLD_CYC       = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned RC_CYC         = 2 * ((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  // read cycle of at least the edo threshold lets data be taken on the rising read strobe
  localparam logic        SAMPLE_ON_RISE = 1'(RC_CYC * CLK_NS >= T_EDO_RC_NS);
  // busy may show up a while after the last strobe; the guard also covers the two sync stages
  localparam int unsigned T_WB_NS        = 100;
  localparam logic [3:0]  WB_CYC         = 4'((T_WB_NS + CLK_NS - 1) / CLK_NS + 2);

  // bus operation kinds
  typedef enum logic [1:0] {
    NBI_OP_CMD  = 2'h0,
    NBI_OP_ADDR = 2'h1,
    NBI_OP_WR   = 2'h2,
    NBI_OP_RD   = 2'h3
  } nbi_op_t;

  // strobe phase machine, gray coded along idle-setup-pulse-hold
  typedef enum logic [1:0] {
    NBI_ST_IDLE  = 2'b00,
    NBI_ST_SETUP = 2'b01,
    NBI_ST_PULSE = 2'b11,
    NBI_ST_HOLD  = 2'b10
  } nbi_state_t;

  localparam logic [7:0] CMD_READ_MODE   = 8'h00;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_ADDR_STATUS = 8'h78;
  localparam logic [7:0] STATUS_WP_ABORT = 8'h60;

  localparam int unsigned ADDR_CYCLES    = 5;
  localparam logic [2:0]  ADDR_LAST      = 3'h4;

  // address fields
  typedef struct packed {
    logic [12:0] column;
    logic [5:0]  page;
    logic [18:0] block;
  } nbi_addr_t;

  // byte of one address cycle; x16 narrows column and zeroes illegal bits
  function automatic logic [7:0] nbi_addr_byte(input nbi_addr_t a,
                                               input logic [2:0] idx,
                                               input logic x16,
                                               input logic dual_die);
    logic [12:0] col;
    logic [7:0]  b;
    col = a.column;
    b   = 8'h00;
    if (x16) begin
      col[12] = 1'b0;
      if (col[11]) col[10:7] = 4'h0;
    end else if (col[12]) begin
      col[11:8] = 4'h0;
    end
    case (idx)
      3'h0: b = col[7:0];
      3'h1: b = {3'b000, col[12:8]};
      3'h2: b = {a.block[7:6], a.page};
      3'h3: b = a.block[15:8];
      3'h4: b = {5'b0_0000, dual_die & a.block[18], a.block[17:16]};
      default: b = 8'h00;
    endcase
    return b;
  endfunction

endpackage

// File: inc/nbi_strobe_if.sv
// interface: one strobe request between sequencer and timing engine
`timescale 1ns/1ps
interface nbi_strobe_if;
  import nbi_pkg::*;
  logic        req;
  nbi_op_t     op;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport seq (output req, output op, output wdata, input done, input rdata);
  modport eng (input req, input op, input wdata, output done, output rdata);
endinterface

// File: rtl/nbi_strobe_engine.sv
// strobe timing engine: drives one command, address or data bus cycle
`timescale 1ns/1ps
module nbi_strobe_engine
  import nbi_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  nbi_strobe_if.eng  s,
  input  wire logic  i_x16,
  input  wire logic  i_abort,
  input  wire logic [15:0] i_io,
  output logic       o_cle,
  output logic       o_ale,
  output logic       o_write_strobe_n,
  output logic       o_read_strobe_n,
  output logic [15:0] o_io,
  output logic       o_io_oe
);

  nbi_state_t state;
  logic [3:0] cnt;
  nbi_op_t    op;

  always_ff @(posedge i_clk) begin
    if (i_rst || i_abort) begin
      state <= NBI_ST_IDLE;
      cnt   <= 4'h0;
      op    <= NBI_OP_CMD;
    end else begin
      case (state)
        NBI_ST_IDLE: begin
          if (s.req) begin
            op    <= s.op;
            cnt   <= SETUP_CYC;
            state <= NBI_ST_SETUP;
          end
        end
        NBI_ST_SETUP: begin
          if (cnt <= 4'h1) begin
            cnt   <= PULSE_CYC;
            state <= NBI_ST_PULSE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        NBI_ST_PULSE: begin
          if (cnt <= 4'h1) begin
            cnt   <= HOLD_CYC;
            state <= NBI_ST_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        NBI_ST_HOLD: begin
          if (cnt <= 4'h1) state <= NBI_ST_IDLE;
          else cnt <= cnt - 4'h1;
        end
        default: state <= NBI_ST_IDLE;
      endcase
    end
  end

  // pins; latch lines held for the whole cycle, never both high
  always_ff @(posedge i_clk) begin
    if (i_rst || i_abort) begin
      o_cle            <= 1'b0;
      o_ale            <= 1'b0;
      o_write_strobe_n <= 1'b1;
      o_read_strobe_n  <= 1'b1;
      o_io             <= 16'h0000;
      o_io_oe          <= 1'b0;
    end else if (state == NBI_ST_IDLE && s.req) begin
      o_cle   <= (s.op == NBI_OP_CMD);
      o_ale   <= (s.op == NBI_OP_ADDR);
      o_io_oe <= (s.op != NBI_OP_RD);
      // upper byte zero for command and address cycles
      if (s.op == NBI_OP_WR && i_x16) o_io <= s.wdata;
      else o_io <= {8'h00, s.wdata[7:0]};
    end else if (state == NBI_ST_SETUP && cnt <= 4'h1) begin
      // read strobe falls for reads, write strobe for all other ops
      if (op == NBI_OP_RD) o_read_strobe_n <= 1'b0;
      else o_write_strobe_n <= 1'b0;
    end else if (state == NBI_ST_PULSE && cnt <= 4'h1) begin
      o_write_strobe_n <= 1'b1;
      o_read_strobe_n  <= 1'b1;
    end else if (state == NBI_ST_HOLD && cnt <= 4'h1) begin
      o_cle   <= 1'b0;
      o_ale   <= 1'b0;
      o_io_oe <= 1'b0;
    end
  end

  // read data sampled at the end of the pulse, as the read strobe rises
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s.rdata <= 16'h0000;
    end else if (op == NBI_OP_RD && state == NBI_ST_PULSE && cnt <= 4'h1) begin
      s.rdata <= i_x16 ? i_io : {8'h00, i_io[7:0]};
    end
  end

  assign s.done = (state == NBI_ST_HOLD) && (cnt <= 4'h1);

  // edo: sampling on the next falling edge is not used; this clock gives a long read cycle
  logic unused_edo;
  assign unused_edo = SAMPLE_ON_RISE;

endmodule

// File: rtl/nbi_host.sv
// host controller for the nand asynchronous bus: command, address, data sequences
`timescale 1ns/1ps
// How it works
// - five address cycles, x8 single-die layout
// - column bit 12 set forces 11..8 zero
// - x16: upper byte low, column 11..0 rules
// - commands and addresses on low byte only
// - x16 upper byte zero during commands
// - bits outside address space driven low
// - data on 8 or 16 lines by width
// - sample edge fixed at the rising read strobe
// - read-mode command after addressed status read left to software
module nbi_host
  import nbi_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // configuration
  input  wire logic        i_x16,
  input  wire logic        i_dual_die,
  input  wire logic        i_write_enable,
  // request port
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  input  wire logic        i_has_cmd1,
  input  wire logic [7:0]  i_cmd1,
  input  wire logic [2:0]  i_addr_cycles,
  input  wire logic [12:0] i_column,
  input  wire logic [5:0]  i_page,
  input  wire logic [18:0] i_block,
  input  wire logic        i_has_cmd2,
  input  wire logic [7:0]  i_cmd2,
  input  wire logic        i_data_dir_rd,
  input  wire logic [11:0] i_data_count,
  input  wire logic        i_wait_ready,
  // write data stream
  input  wire logic [15:0] i_wdata,
  output logic             o_wdata_ready,
  // read data stream
  output logic [15:0]      o_rdata,
  output logic             o_rdata_valid,
  output logic             o_done,
  output logic             o_busy,
  // nand pins
  output logic             o_chip_enable_n,
  output logic             o_cle,
  output logic             o_ale,
  output logic             o_write_strobe_n,
  output logic             o_read_strobe_n,
  output logic             o_write_protect_n,
  input  wire logic [15:0] i_io,
  output logic [15:0]      o_io,
  output logic             o_io_oe,
  input  wire logic        i_ready_busy_n
);

  typedef enum logic [2:0] {
    NBI_SQ_IDLE = 3'b000,
    NBI_SQ_CMD1 = 3'b001,
    NBI_SQ_ADDR = 3'b011,
    NBI_SQ_CMD2 = 3'b010,
    NBI_SQ_WAIT = 3'b110,
    NBI_SQ_DATA = 3'b111,
    NBI_SQ_END  = 3'b101
  } nbi_seq_t;

  nbi_strobe_if st ();

  nbi_seq_t    sq;
  logic        issued;
  logic [2:0]  acnt;
  logic [11:0] dcnt;
  nbi_addr_t   addr;
  logic [7:0]  cmd1;
  logic [7:0]  cmd2;
  logic        has_cmd2;
  logic        rd;
  logic [2:0]  ncyc;
  logic        wait_rdy;
  logic        rb_q;
  logic        rb_q2;
  logic [3:0]  wcnt;

  ////////////////////////////////////////////////////////////////////////////////
  // ready/busy is asynchronous; two stages synchronise it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rb_q  <= 1'b0;
      rb_q2 <= 1'b0;
    end else begin
      rb_q  <= i_ready_busy_n;
      rb_q2 <= rb_q;
    end
  end

  // write protect follows software; low rejects program and erase
  always_ff @(posedge i_clk) begin
    if (i_rst) o_write_protect_n <= 1'b0;
    else o_write_protect_n <= i_write_enable;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request capture
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr     <= '0;
      cmd1     <= 8'h00;
      cmd2     <= 8'h00;
      has_cmd2 <= 1'b0;
      rd       <= 1'b0;
      ncyc     <= 3'h0;
      wait_rdy <= 1'b0;
    end else if (sq == NBI_SQ_IDLE && i_req_valid) begin
      addr     <= '{column: i_column, page: i_page, block: i_block};
      cmd1     <= i_cmd1;
      cmd2     <= i_cmd2;
      has_cmd2 <= i_has_cmd2;
      rd       <= i_data_dir_rd;
      ncyc     <= (i_addr_cycles > 3'(ADDR_CYCLES)) ? 3'(ADDR_CYCLES) : i_addr_cycles;
      wait_rdy <= i_wait_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sq     <= NBI_SQ_IDLE;
      issued <= 1'b0;
      acnt   <= 3'h0;
      dcnt   <= 12'h000;
      wcnt   <= WB_CYC;
    end else begin
      if (st.req) issued <= 1'b1;
      if (st.done) issued <= 1'b0;
      // guard counts down only while waiting, reloads everywhere else
      if (sq == NBI_SQ_WAIT) wcnt <= (wcnt != 4'h0) ? wcnt - 4'h1 : 4'h0;
      else wcnt <= WB_CYC;
      case (sq)
        NBI_SQ_IDLE: begin
          if (i_req_valid) begin
            acnt <= 3'h0;
            dcnt <= i_data_count;
            if (i_has_cmd1) sq <= NBI_SQ_CMD1;
            else if (i_addr_cycles != 3'h0) sq <= NBI_SQ_ADDR;
            else if (i_has_cmd2) sq <= NBI_SQ_CMD2;
            else sq <= NBI_SQ_WAIT;
          end
        end
        NBI_SQ_CMD1: begin
          if (st.done) begin
            if (ncyc != 3'h0) sq <= NBI_SQ_ADDR;
            else if (has_cmd2) sq <= NBI_SQ_CMD2;
            else sq <= NBI_SQ_WAIT;
          end
        end
        NBI_SQ_ADDR: begin
          if (st.done) begin
            acnt <= acnt + 3'h1;
            if (acnt + 3'h1 >= ncyc || acnt == ADDR_LAST) begin
              sq <= has_cmd2 ? NBI_SQ_CMD2 : NBI_SQ_WAIT;
            end
          end
        end
        NBI_SQ_CMD2: begin
          if (st.done) sq <= NBI_SQ_WAIT;
        end
        NBI_SQ_WAIT: begin
          // busy die ignores data output except status; wait for ready
          // ready seen before the guard may predate the busy edge; not trusted
          if (!wait_rdy || (wcnt == 4'h0 && rb_q2)) begin
            sq <= (dcnt != 12'h000) ? NBI_SQ_DATA : NBI_SQ_END;
          end
        end
        NBI_SQ_DATA: begin
          if (st.done) begin
            dcnt <= dcnt - 12'h001;
            if (dcnt == 12'h001) sq <= NBI_SQ_END;
          end
        end
        NBI_SQ_END: sq <= NBI_SQ_IDLE;
        default: sq <= NBI_SQ_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strobe requests; status commands 70h/78h may be sent to a busy die
  // software must send read-mode after an addressed status read
  always_comb begin
    st.req   = 1'b0;
    st.op    = NBI_OP_CMD;
    st.wdata = 16'h0000;
    if (!issued && !st.done) begin
      case (sq)
        NBI_SQ_CMD1: begin
          st.req   = 1'b1;
          st.wdata = {8'h00, cmd1};
        end
        NBI_SQ_ADDR: begin
          st.req   = 1'b1;
          st.op    = NBI_OP_ADDR;
          // plane bit passed through, die bit only when dual
          st.wdata = {8'h00, nbi_addr_byte(addr, acnt, i_x16, i_dual_die)};
        end
        NBI_SQ_CMD2: begin
          st.req   = 1'b1;
          st.wdata = {8'h00, cmd2};
        end
        NBI_SQ_DATA: begin
          st.req   = 1'b1;
          st.op    = rd ? NBI_OP_RD : NBI_OP_WR;
          st.wdata = i_wdata;
        end
        default: st.req = 1'b0;
      endcase
    end
  end

  nbi_strobe_engine u_engine (
    .i_clk            (i_clk),
    .i_rst            (i_rst),
    .s                (st.eng),
    .i_x16            (i_x16),
    .i_abort          (1'b0),
    .i_io             (i_io),
    .o_cle            (o_cle),
    .o_ale            (o_ale),
    .o_write_strobe_n (o_write_strobe_n),
    .o_read_strobe_n  (o_read_strobe_n),
    .o_io             (o_io),
    .o_io_oe          (o_io_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // chip enable low only inside a sequence; raising it lets the die stand by
  always_ff @(posedge i_clk) begin
    if (i_rst) o_chip_enable_n <= 1'b1;
    else if (sq == NBI_SQ_IDLE && i_req_valid) o_chip_enable_n <= 1'b0;
    else if (sq == NBI_SQ_END) o_chip_enable_n <= 1'b1;
  end

  // outputs to the user
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata       <= 16'h0000;
      o_rdata_valid <= 1'b0;
      o_done        <= 1'b0;
    end else begin
      o_rdata_valid <= (sq == NBI_SQ_DATA) && rd && st.done;
      if ((sq == NBI_SQ_DATA) && rd && st.done) o_rdata <= st.rdata;
      o_done <= (sq == NBI_SQ_END);
    end
  end

  assign o_req_ready   = (sq == NBI_SQ_IDLE);
  assign o_wdata_ready = (sq == NBI_SQ_DATA) && !rd && st.done;
  assign o_busy        = (sq != NBI_SQ_IDLE);

endmodule

// File: tb/nbi_host_assertions.sv
// checker: pin-level properties of the nand bus host
`timescale 1ns/1ps
module nbi_host_assertions (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_x16,
  input  wire logic        i_write_enable,
  input  wire logic        o_done,
  input  wire logic [15:0] o_rdata,
  input  wire logic        o_rdata_valid,
  input  wire logic        o_chip_enable_n,
  input  wire logic        o_cle,
  input  wire logic        o_ale,
  input  wire logic        o_write_strobe_n,
  input  wire logic        o_read_strobe_n,
  input  wire logic        o_write_protect_n,
  input  wire logic [15:0] o_io,
  input  wire logic        o_io_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  sequence rd_pulse;
    $fell(o_read_strobe_n) ##1 $rose(o_read_strobe_n);
  endsequence
  sequence wr_pulse;
    $fell(o_write_strobe_n) ##1 $rose(o_write_strobe_n);
  endsequence
  ////////////////////////////////////////
  latch_excl_a: assert property (!(o_cle && o_ale))
    else $error("cle and ale high together");
  strobe_excl_a: assert property (!(!o_write_strobe_n && !o_read_strobe_n))
    else $error("both strobes low");
  idle_strobe_a: assert property (o_chip_enable_n |-> o_write_strobe_n && o_read_strobe_n)
    else $error("strobe while deselected");
  low_byte_a: assert property ((o_cle || o_ale) && o_io_oe |-> o_io[15:8] == 8'h00)
    else $error("upper byte set in command or address cycle");
  wr_frame_a: assert property (wr_pulse |-> !o_chip_enable_n && o_io_oe && $stable(o_io))
    else $error("write strobe edge without stable driven bus");
  we_width_a: assert property ($fell(o_write_strobe_n) |=> o_write_strobe_n)
    else $error("write strobe low too long");
  rd_frame_a: assert property (!o_read_strobe_n |-> !o_io_oe && !o_cle && !o_ale
    && !o_chip_enable_n) else $error("read strobe in wrong mode");
  rd_sample_a: assert property (rd_pulse |-> ##[0:2] o_rdata_valid)
    else $error("read word not delivered");
  x8_width_a: assert property (!i_x16 |-> (!o_io_oe || o_io[15:8] == 8'h00)
    && (!o_rdata_valid || o_rdata[15:8] == 8'h00)) else $error("x8 upper byte used");
  wp_follow_a: assert property (!$past(i_rst) |->
    o_write_protect_n == $past(i_write_enable)) else $error("write protect not following");
  done_ce_a: assert property (o_done |-> ##[0:1] o_chip_enable_n)
    else $error("chip enable held after done");
endmodule

bind nbi_host nbi_host_assertions u_chk (.i_clk, .i_rst, .i_x16, .i_write_enable, .o_done,
  .o_rdata, .o_rdata_valid, .o_chip_enable_n, .o_cle, .o_ale, .o_write_strobe_n,
  .o_read_strobe_n, .o_write_protect_n, .o_io, .o_io_oe);

// File: tb/nbi_flash_model.sv
// behavioural flash die on the far side of the nand bus host
`timescale 1ns/1ps
module nbi_flash_model
  import nbi_pkg::*;
#(
  parameter int BUSY_NS = 300
) (
  input  wire logic        i_ce_n,
  input  wire logic        i_cle,
  input  wire logic        i_ale,
  input  wire logic        i_we_n,
  input  wire logic        i_re_n,
  input  wire logic        i_wp_n,
  input  wire logic        i_busy,
  input  wire logic [15:0] i_host_io,
  input  wire logic        i_host_oe,
  output logic [15:0]      o_bus,
  output logic             o_rb_n
);
  logic [7:0]  cmd_log[$];
  logic [7:0]  addr_log[$];
  logic [15:0] data_log[$];
  logic [7:0]  last_cmd = 8'h00;
  logic [15:0] dq       = 16'h0000;
  logic [15:0] rd_idx   = 16'h0000;
  logic        drv      = 1'b0;
  logic        ab       = 1'b0;
  logic        bz;
  logic        st;
  logic        sc;
  assign bz     = i_busy | ab;
  assign st     = (last_cmd == CMD_STATUS) || (last_cmd == CMD_ADDR_STATUS);
  assign sc     = (i_host_io[7:0] == CMD_STATUS) || (i_host_io[7:0] == CMD_ADDR_STATUS);
  assign o_rb_n = ~bz;
  // no pull on io: an undriven bus shows the inverse of the last word
  assign o_bus  = i_host_oe ? i_host_io : (drv ? dq : ~dq);
  ////////////////////////////////////////
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_re_n && !(i_cle && i_ale)) begin
      if (i_cle && (!bz || sc)) begin
        cmd_log.push_back(i_host_io[7:0]);
        last_cmd <= i_host_io[7:0];
        rd_idx <= 16'h0000;
        if (i_host_io[7:0] == 8'h30) begin
          ab <= 1'b1;
          ab <= #BUSY_NS 1'b0;
        end
      end else if (i_ale && (!bz || last_cmd == CMD_ADDR_STATUS)) begin
        addr_log.push_back(i_host_io[7:0]);
      end else if (!i_cle && !i_ale && !bz) begin
        data_log.push_back(i_host_io);
      end
    end
  end
  always @(negedge i_re_n) begin
    if (!i_ce_n && !i_cle && !i_ale && i_we_n) begin
      drv <= st || !bz;
      dq <= st ? {8'h00, i_wp_n, ~bz, 6'h00} : 16'hC35A + rd_idx;
      rd_idx <= rd_idx + (st ? 16'h0000 : 16'h0001);
    end
  end
  always @(posedge i_ce_n) drv <= 1'b0;
  // write protect falling mid-operation aborts it
  always @(negedge i_wp_n) if (ab) ab <= 1'b0;
endmodule

// File: tb/tb.sv
// testbench: nand bus host against a behavioural flash die
`timescale 1ns/1ps
module tb;
  logic        i_clk, i_rst, x16, dual, we_en, busy, req, has2, rd, wt, wrdy, rv, done, ready;
  logic        ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n, bsy;
  logic [7:0]  c1, c2;
  logic [2:0]  nac;
  logic [12:0] col;
  logic [5:0]  pg;
  logic [18:0] blk;
  logic [11:0] cnt;
  logic [15:0] wd, rdat, io_h, bus;
  logic [15:0] rq[$];
  int          err_count, cmp_count, cyc;

  nbi_host dut (.i_clk, .i_rst, .i_x16(x16), .i_dual_die(dual), .i_write_enable(we_en),
    .i_req_valid(req), .o_req_ready(ready), .i_has_cmd1(1'b1), .i_cmd1(c1),
    .i_addr_cycles(nac), .i_column(col), .i_page(pg), .i_block(blk), .i_has_cmd2(has2),
    .i_cmd2(c2), .i_data_dir_rd(rd), .i_data_count(cnt), .i_wait_ready(wt), .i_wdata(wd),
    .o_wdata_ready(wrdy), .o_rdata(rdat), .o_rdata_valid(rv), .o_done(done), .o_busy(bsy),
    .o_chip_enable_n(ce_n), .o_cle(cle), .o_ale(ale), .o_write_strobe_n(we_n),
    .o_read_strobe_n(re_n), .o_write_protect_n(wp_n), .i_io(bus), .o_io(io_h),
    .o_io_oe(oe), .i_ready_busy_n(rb_n));
  nbi_flash_model mdl (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n),
    .i_re_n(re_n), .i_wp_n(wp_n), .i_busy(busy), .i_host_io(io_h), .i_host_oe(oe),
    .o_bus(bus), .o_rb_n(rb_n));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(negedge i_clk) begin
    if (wrdy) wd <= wd + 16'h1111;
    if (rv) rq.push_back(rdat);
  end
  // a hung handshake must still reach the verdict
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      stop_test;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic go(input logic [7:0] a, input logic [2:0] n, input logic h2,
                    input logic [7:0] b, input logic r, input logic [11:0] k, input logic w);
    int i;
    i = 0;
    while (ready !== 1'b1 && i < 50) begin
      @(negedge i_clk);
      i++;
    end
    c1 = a;
    nac = n;
    has2 = h2;
    c2 = b;
    rd = r;
    cnt = k;
    wt = w;
    req = 1'b1;
    @(negedge i_clk);
    req = 1'b0;
    chk(16'({bsy, ce_n}), 16'h0002);
    i = 0;
    while (done !== 1'b1 && i < 500) begin
      @(negedge i_clk);
      i++;
    end
    chk(16'({done, bsy, ce_n}), 16'h0005);
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_pins;
    chk({9'h000, ce_n, cle, ale, we_n, re_n, wp_n, oe}, 16'h004C);
    we_en = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(16'(wp_n), 16'h0001);
  endtask
  task automatic t_prog(input logic x, input logic dl, input logic [12:0] c,
                        input logic [5:0] p, input logic [18:0] b, input logic [39:0] ea,
                        input logic [15:0] m);
    int a0;
    int d0;
    int n;
    x16 = x;
    dual = dl;
    col = c;
    pg = p;
    blk = b;
    wd = 16'h1234;
    a0 = mdl.addr_log.size();
    d0 = mdl.data_log.size();
    go(8'h80, 3'h5, 1'b1, 8'h10, 1'b0, 12'h003, 1'b0);
    n = mdl.cmd_log.size();
    chk({mdl.cmd_log[n-2], mdl.cmd_log[n-1]}, 16'h8010);
    for (int i = 0; i < 5; i++) chk(16'(mdl.addr_log[a0+i]), 16'(ea[39-8*i -: 8]));
    for (int i = 0; i < 3; i++) chk(mdl.data_log[d0+i] & m, (16'h1234 + 16'(i) * 16'h1111) & m);
  endtask
  task automatic t_read;
    rq.delete();
    go(8'h00, 3'h5, 1'b1, 8'h30, 1'b1, 12'h003, 1'b1);
    chk(16'(rq.size()), 16'h0003);
    for (int i = 0; i < 3; i++) chk(rq[i], 16'hC35A + 16'(i));
  endtask
  task automatic t_status;
    int n;
    x16 = 1'b0;
    busy = 1'b1;
    n = mdl.cmd_log.size();
    go(8'h90, 3'h0, 1'b0, 8'h00, 1'b0, 12'h000, 1'b0);
    chk(16'(mdl.cmd_log.size()), 16'(n));
    n = mdl.addr_log.size();
    go(8'h78, 3'h3, 1'b0, 8'h00, 1'b0, 12'h000, 1'b0);
    chk(16'(mdl.addr_log.size()), 16'(n + 3));
    rq.delete();
    go(8'h70, 3'h0, 1'b0, 8'h00, 1'b1, 12'h001, 1'b0);
    chk(rq[0], 16'h0080);
    busy = 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    {i_rst, x16, dual, we_en, busy, req, has2, rd, wt} = 9'h100;
    {c1, c2, nac, cnt, wd} = '0;
    {col, pg, blk} = '0;
    err_count = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    t_pins;
    // x8 single die, column 12 set forces 11..8 low, block 18 dropped
    t_prog(1'b0, 1'b0, 13'h1F34, 6'h2B, 19'h7_ABC5, 40'h34_10EB_AB03, 16'h00FF);
    // x16 dual die, column 11 set forces 10..7 low, block 18 picks die
    t_prog(1'b1, 1'b1, 13'h1ABC, 6'h15, 19'h4_0140, 40'h3C_0855_0104, 16'hFFFF);
    t_read;
    t_status;
    stop_test;
  end
endmodule
